// ===== hdl/drm_decoder.sv
/*
 * Register map of a dual-port USB controller behind a Wishbone classic slave:
 * two 512-word port windows, shared registers mirrored in both, an init gate
 * in front of the bus configuration, and per-port interrupt flags.
 * Assumes events are one-cycle pulses on clk_i; line inputs come from pins.
 */
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module drm_decoder #(
    parameter logic [7:0] REVISION = 8'h5A  // Arbitrary value
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [15:0] dev_event_i,
    input  wire logic [15:0] host_event_i,
    input  wire logic [15:0] cpu_event_i,
    input  wire logic [15:0] fifo_event_i,
    input  wire logic [1:0]  pm_done_i,
    input  wire logic [7:0]  dev_line_i,
    input  wire logic [15:0] host_line_i,
    output logic             irq_o,
    output logic             init_done_o,
    output logic             endian_o,
    output logic             bus_width_select_o,
    output logic      [15:0] chip_reset_o,
    output logic      [15:0] pm_ctl_o,
    output logic      [15:0] vbus_ctl_o,
    output logic      [15:0] xcvr_ctl_o,
    output logic      [15:0] tuning_o,
    output logic      [15:0] role_o,
    output logic      [15:0] wake_timer_o,
    output logic      [7:0]  clock_source_choice_o,
    output logic      [7:0]  cpu_config_o
);
    typedef struct packed {
        logic            ack;
        logic [31:0]     dat;
        logic            irq;
        logic            init_done;
        logic            endian;
        logic            bus_width;
        logic [1:0][7:0] st_dev;
        logic [1:0][7:0] st_host;
        logic [1:0][7:0] st_cpu;
        logic [1:0][7:0] st_fifo;
        logic [1:0]      st_pm;
        logic [1:0][7:0] en_top;
        logic [1:0][7:0] en_dev;
        logic [1:0][7:0] en_host;
        logic [1:0][7:0] en_cpu;
        logic [1:0][7:0] en_fifo;
        logic [1:0][7:0] chip_rst;
        logic [1:0][7:0] pm_ctl;
        logic [1:0][7:0] vbus;
        logic [1:0][7:0] xcvr;
        logic [1:0][7:0] tuning;
        logic [1:0][7:0] role;
        logic [7:0]      wake_h;
        logic [7:0]      wake_l;
        logic [7:0]      clk_sel;
        logic [7:0]      cpu_cfg;
    } drm_state_t;

    drm_state_t      st_q;
    drm_state_t      st_d;
    logic [7:0]      dev_line_s;
    logic [15:0]     host_line_s;
    logic [1:0][7:0] top_flags;
    logic [1:0]      port_int;
    logic            req;
    logic            wr;
    logic            port;
    logic [8:0]      idx;
    logic [7:0]      wbyte;

    drm_sync #(.WIDTH(8)) u_dev_line (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (dev_line_i),
        .level_o (dev_line_s)
    );

    drm_sync #(.WIDTH(16)) u_host_line (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (host_line_i),
        .level_o (host_line_s)
    );

    assign req   = wb_cyc_i && wb_stb_i && !st_q.ack;
    assign wr    = req && wb_we_i && wb_sel_i[0];
    assign port  = wb_adr_i[11];                 // see R01 see R02
    assign idx   = wb_adr_i[10:2];
    assign wbyte = wb_dat_i[7:0];

    // Top flags summarise enabled group flags of each port
    for (genvar p = 0; p < 2; p++) begin : g_top
        logic [7:0] flags;
        always_comb begin
            flags                          = 8'h00;
            flags[drm_pkg::TOP_DEV_BIT]    = |(st_q.st_dev[p] & st_q.en_dev[p]);   // see R10
            flags[drm_pkg::TOP_HOST_BIT]   = |(st_q.st_host[p] & st_q.en_host[p]);
            flags[drm_pkg::TOP_CPU_BIT]    = |(st_q.st_cpu[p] & st_q.en_cpu[p]);
            flags[drm_pkg::TOP_FIFO_BIT]   = |(st_q.st_fifo[p] & st_q.en_fifo[p]);
            flags[drm_pkg::TOP_PM_BIT]     = st_q.st_pm[p];
        end
        assign top_flags[p] = flags;
        assign port_int[p]  = |(flags & st_q.en_top[p]);                           // see R10
    end

    always_comb begin
        st_d     = st_q;
        st_d.ack = req;
        st_d.irq = |port_int;
        // Sticky flags; a new event wins over a clear in the same cycle
        for (int p = 0; p < 2; p++) begin
            st_d.st_dev[p]  = st_q.st_dev[p] | (p == 0 ? dev_event_i[8*p +: 8] : 8'h00);  // see R03
            st_d.st_host[p] = st_q.st_host[p] | host_event_i[8*p +: 8];
            st_d.st_cpu[p]  = st_q.st_cpu[p] | cpu_event_i[8*p +: 8];
            st_d.st_fifo[p] = st_q.st_fifo[p] | fifo_event_i[8*p +: 8];
            st_d.st_pm[p]   = st_q.st_pm[p] | pm_done_i[p];
        end
        if (!st_q.init_done) begin
            // Any write, at any address, configures the bus
            if (wr) begin                                                     // see R06 see R07
                st_d.endian    = wb_dat_i[drm_pkg::CFG_ENDIAN_BIT];
                st_d.bus_width = wb_dat_i[drm_pkg::CFG_WIDTH_BIT];
                st_d.init_done = 1'b1;
            end
        end else if (wr) begin
            unique case (idx)
                drm_pkg::IX_DEV_EN:   st_d.en_dev[port]   = port ? 8'h00 : wbyte;     // see R03
                drm_pkg::IX_TOP_EN:   st_d.en_top[port]   = wbyte;
                drm_pkg::IX_HOST_EN:  st_d.en_host[port]  = wbyte;
                drm_pkg::IX_CPU_EN:   st_d.en_cpu[port]   = wbyte;
                drm_pkg::IX_FIFO_EN:  st_d.en_fifo[port]  = wbyte;
                drm_pkg::IX_TOP_CLR:  st_d.st_pm[port]    = st_q.st_pm[port] & ~wbyte[drm_pkg::TOP_PM_BIT]
                                                            | pm_done_i[port];
                drm_pkg::IX_DEV_CLR:  st_d.st_dev[port]   = st_q.st_dev[port] & ~wbyte
                                                            | (port ? 8'h00 : dev_event_i[7:0]);
                drm_pkg::IX_HOST_CLR: st_d.st_host[port]  = st_q.st_host[port] & ~wbyte
                                                            | host_event_i[8*port +: 8];
                drm_pkg::IX_CPU_CLR:  st_d.st_cpu[port]   = st_q.st_cpu[port] & ~wbyte
                                                            | cpu_event_i[8*port +: 8];
                drm_pkg::IX_FIFO_CLR: st_d.st_fifo[port]  = st_q.st_fifo[port] & ~wbyte
                                                            | fifo_event_i[8*port +: 8];
                drm_pkg::IX_CHIP_RST: st_d.chip_rst[port] = wbyte;
                drm_pkg::IX_PM_CTL:   st_d.pm_ctl[port]   = wbyte;
                drm_pkg::IX_VBUS_CTL: st_d.vbus[port]     = wbyte;
                drm_pkg::IX_XCVR_CTL: st_d.xcvr[port]     = wbyte;
                drm_pkg::IX_TUNING:   st_d.tuning[port]   = wbyte;
                drm_pkg::IX_ROLE:     st_d.role[port]     = wbyte;
                // Shared registers: one copy, reached from either window
                drm_pkg::IX_WAKE_H:   st_d.wake_h         = wbyte;                    // see R04 see R05
                drm_pkg::IX_WAKE_L:   st_d.wake_l         = wbyte;                    // see R04
                drm_pkg::IX_CLK_SEL:  st_d.clk_sel        = wbyte;                    // see R04
                drm_pkg::IX_CPU_CFG:  st_d.cpu_cfg        = wbyte;                    // see R04
                default: ;                                                            // see R08 see R11
            endcase
        end
        // Read data; write-only and unassigned words read as zero
        st_d.dat = 32'h0000_0000;
        if (req && !wb_we_i && st_q.init_done) begin                                  // see R06
            unique case (idx)
                drm_pkg::IX_TOP_FLAGS:  st_d.dat[7:0] = top_flags[port];              // see R10
                drm_pkg::IX_DEV_FLAGS:  st_d.dat[7:0] = st_q.st_dev[port];
                drm_pkg::IX_HOST_FLAGS: st_d.dat[7:0] = st_q.st_host[port];
                drm_pkg::IX_CPU_FLAGS:  st_d.dat[7:0] = st_q.st_cpu[port];
                drm_pkg::IX_FIFO_FLAGS: st_d.dat[7:0] = st_q.st_fifo[port];
                drm_pkg::IX_PORT_SUM:   st_d.dat[7:0] = {6'h00, port_int};            // see R04
                drm_pkg::IX_TOP_EN:     st_d.dat[7:0] = st_q.en_top[port];
                drm_pkg::IX_DEV_EN:     st_d.dat[7:0] = st_q.en_dev[port];
                drm_pkg::IX_HOST_EN:    st_d.dat[7:0] = st_q.en_host[port];
                drm_pkg::IX_CPU_EN:     st_d.dat[7:0] = st_q.en_cpu[port];
                drm_pkg::IX_FIFO_EN:    st_d.dat[7:0] = st_q.en_fifo[port];
                drm_pkg::IX_REVISION:   st_d.dat[7:0] = REVISION;
                drm_pkg::IX_CHIP_RST:   st_d.dat[7:0] = st_q.chip_rst[port];
                drm_pkg::IX_PM_CTL:     st_d.dat[7:0] = st_q.pm_ctl[port];
                drm_pkg::IX_WAKE_H:     st_d.dat[7:0] = st_q.wake_h;                  // see R05
                drm_pkg::IX_WAKE_L:     st_d.dat[7:0] = st_q.wake_l;
                drm_pkg::IX_VBUS_CTL:   st_d.dat[7:0] = st_q.vbus[port];
                drm_pkg::IX_XCVR_CTL:   st_d.dat[7:0] = st_q.xcvr[port];
                drm_pkg::IX_DEV_LINE:   st_d.dat[7:0] = port ? 8'h00 : dev_line_s;    // see R03
                drm_pkg::IX_HOST_LINE:  st_d.dat[7:0] = host_line_s[8*port +: 8];
                drm_pkg::IX_TUNING:     st_d.dat[7:0] = st_q.tuning[port];
                drm_pkg::IX_ROLE:       st_d.dat[7:0] = st_q.role[port];
                drm_pkg::IX_CLK_SEL:    st_d.dat[7:0] = st_q.clk_sel;
                drm_pkg::IX_CPU_CFG:    st_d.dat[7:0] = st_q.cpu_cfg;
                default:                st_d.dat      = 32'h0000_0000;                // see R11
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q          <= '0;
            st_q.chip_rst <= {drm_pkg::RST_CHIP_RST, drm_pkg::RST_CHIP_RST};
            st_q.xcvr     <= {drm_pkg::RST_XCVR_CTL, drm_pkg::RST_XCVR_CTL};
        end else begin
            st_q <= st_d;
        end
    end

    assign wb_ack_o              = st_q.ack;
    assign wb_dat_o              = st_q.dat;
    assign irq_o                 = st_q.irq;
    assign init_done_o           = st_q.init_done;
    assign endian_o              = st_q.endian;
    assign bus_width_select_o    = st_q.bus_width;
    assign chip_reset_o          = st_q.chip_rst;
    assign pm_ctl_o              = st_q.pm_ctl;
    assign vbus_ctl_o            = st_q.vbus;
    assign xcvr_ctl_o            = st_q.xcvr;
    assign tuning_o              = st_q.tuning;
    assign role_o                = st_q.role;
    assign wake_timer_o          = {st_q.wake_h, st_q.wake_l};                        // see R05
    assign clock_source_choice_o = st_q.clk_sel;
    assign cpu_config_o          = st_q.cpu_cfg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ack_next;
        req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");

    property p_uninit_read_zero;
        (req && !wb_we_i && !init_done_o) |=> (wb_dat_o == 32'h0000_0000);
    endproperty
    a_uninit_read_zero: assert property (p_uninit_read_zero) else $error("read leaked before init"); // see R06

    property p_uninit_write_cfg;
        (wr && !init_done_o) |=> init_done_o && (endian_o == $past(wb_dat_i[2]))
                                 && (bus_width_select_o == $past(wb_dat_i[1])) && $stable(role_o);
    endproperty
    a_uninit_write_cfg: assert property (p_uninit_write_cfg) else $error("uninit write not steered"); // see R07

    property p_cfg_locked;
        init_done_o |=> init_done_o && $stable(endian_o) && $stable(bus_width_select_o);
    endproperty
    a_cfg_locked: assert property (p_cfg_locked) else $error("bus configuration changed after init"); // see R08

    property p_mirror_alias;
        (wr && init_done_o && port && idx == drm_pkg::IX_CLK_SEL)
            |=> clock_source_choice_o == $past(wb_dat_i[7:0]);
    endproperty
    a_mirror_alias: assert property (p_mirror_alias) else $error("shared alias write lost"); // see R04

    property p_port1_no_dev;
        (req && !wb_we_i && init_done_o && port && idx == drm_pkg::IX_DEV_FLAGS)
            |=> wb_dat_o == 32'h0000_0000;
    endproperty
    a_port1_no_dev: assert property (p_port1_no_dev) else $error("port 1 shows device flags"); // see R03

    property p_irq_summary;
        ##1 irq_o == $past(|port_int);
    endproperty
    a_irq_summary: assert property (p_irq_summary) else $error("irq does not follow enabled flags"); // see R10

    property p_port0_role;
        (wr && init_done_o && !port && idx == drm_pkg::IX_ROLE)
            |=> role_o[7:0] == $past(wb_dat_i[7:0]) && $stable(role_o[15:8]);
    endproperty
    a_port0_role: assert property (p_port0_role) else $error("port 0 write reached wrong window"); // see R01

    property p_port1_role;
        (wr && init_done_o && port && idx == drm_pkg::IX_ROLE)
            |=> role_o[15:8] == $past(wb_dat_i[7:0]) && $stable(role_o[7:0]);
    endproperty
    a_port1_role: assert property (p_port1_role) else $error("port 1 write reached wrong window"); // see R02

    property p_wake_order;
        (wr && init_done_o && idx == drm_pkg::IX_WAKE_H) |=> wake_timer_o[15:8] == $past(wb_dat_i[7:0]);
    endproperty
    a_wake_order: assert property (p_wake_order) else $error("wake timer high byte misplaced"); // see R05

    property p_unmapped_write;
        (wr && init_done_o && idx == 9'h005) |=> $stable(role_o) && $stable(pm_ctl_o) && $stable(xcvr_ctl_o);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write had an effect"); // see R11

    c_init: cover property (wr && !init_done_o);
    c_irq: cover property ($rose(irq_o));
    c_port1_read: cover property (req && !wb_we_i && init_done_o && port);
endmodule
`default_nettype wire

// ===== hdl/drm_pkg.sv
/*
 * Constants of the dual-port register map decoder: word indices of the
 * registers inside one port window, reset values and field positions.
 * Assumes a Wishbone classic bus with 32-bit data; byte address = 4 * index.
 */
// Functional notes
// R01: Indices 0x000-0x1FF form the port 0 window.
// R02: Indices 0x200-0x3FF form the port 1 window.
// R03: Port 1 has no device-side function.
// R04: Shared registers mirror identically in both windows.
// R05: Lower address holds the more significant byte.
// R06: Before initialisation only bus configuration is reachable.
// R07: Uninitialised writes all land in bus configuration.
// R08: After initialisation bus configuration accesses are ignored.
// R09: Software writes bus configuration first after reset.
// R10: Top flags OR enabled groups; enables gate them.
// R11: Unassigned reads give zero; writes do nothing.
package drm_pkg;
    localparam int unsigned IDX_W = 9;
    localparam logic [8:0] IX_TOP_FLAGS  = 9'h000;
    localparam logic [8:0] IX_DEV_FLAGS  = 9'h001;
    localparam logic [8:0] IX_HOST_FLAGS = 9'h002;
    localparam logic [8:0] IX_CPU_FLAGS  = 9'h003;
    localparam logic [8:0] IX_FIFO_FLAGS = 9'h004;
    localparam logic [8:0] IX_PORT_SUM   = 9'h006;
    localparam logic [8:0] IX_TOP_EN     = 9'h008;
    localparam logic [8:0] IX_DEV_EN     = 9'h009;
    localparam logic [8:0] IX_HOST_EN    = 9'h00A;
    localparam logic [8:0] IX_CPU_EN     = 9'h00B;
    localparam logic [8:0] IX_FIFO_EN    = 9'h00C;
    localparam logic [8:0] IX_REVISION   = 9'h010;
    localparam logic [8:0] IX_CHIP_RST   = 9'h011;
    localparam logic [8:0] IX_PM_CTL     = 9'h012;
    localparam logic [8:0] IX_WAKE_H     = 9'h014;
    localparam logic [8:0] IX_WAKE_L     = 9'h015;
    localparam logic [8:0] IX_VBUS_CTL   = 9'h016;
    localparam logic [8:0] IX_XCVR_CTL   = 9'h017;
    localparam logic [8:0] IX_DEV_LINE   = 9'h018;
    localparam logic [8:0] IX_HOST_LINE  = 9'h019;
    localparam logic [8:0] IX_TUNING     = 9'h01B;
    localparam logic [8:0] IX_ROLE       = 9'h01F;
    localparam logic [8:0] IX_CLK_SEL    = 9'h073;
    localparam logic [8:0] IX_CPU_CFG    = 9'h075;
    localparam logic [8:0] IX_BUS_CFG    = 9'h07E;
    localparam logic [8:0] IX_BUS_CFG_LO = 9'h07F;
    localparam logic [8:0] IX_TOP_CLR    = 9'h0E0;
    localparam logic [8:0] IX_DEV_CLR    = 9'h0E1;
    localparam logic [8:0] IX_HOST_CLR   = 9'h0E2;
    localparam logic [8:0] IX_CPU_CLR    = 9'h0E3;
    localparam logic [8:0] IX_FIFO_CLR   = 9'h0E4;
    localparam logic [7:0] RST_CHIP_RST  = 8'h80;
    localparam logic [7:0] RST_XCVR_CTL  = 8'h91;
    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam int unsigned CFG_ENDIAN_BIT = 2;
    localparam int unsigned CFG_WIDTH_BIT  = 1;
    localparam int unsigned TOP_DEV_BIT    = 7;
    localparam int unsigned TOP_HOST_BIT   = 6;
    localparam int unsigned TOP_CPU_BIT    = 5;
    localparam int unsigned TOP_FIFO_BIT   = 4;
    localparam int unsigned TOP_PM_BIT     = 0;
endpackage

// ===== hdl/drm_sync.sv
/*
 * Three-stage synchroniser for pin-level inputs; the output follows once
 * the second and third stages agree. Assumes a single clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module drm_sync #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] level_o
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } drm_sync_st_t;

    drm_sync_st_t st_q;
    drm_sync_st_t st_d;

    if (WIDTH < 1) begin : g_chk
        $error("drm_sync: WIDTH must be at least 1");
    end

    always_comb begin
        st_d    = st_q;
        st_d.s1 = pin_i;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.lvl[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_o = st_q.lvl;
endmodule
`default_nettype wire

// ===== sim/drm_host_model.sv
/*
 * Wishbone classic master that stands in for the host CPU on the register bus.
 * Assumes one caller at a time and a slave that always answers with ack.
 */
`timescale 1ns/1ps
`default_nettype none
module drm_host_model (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [11:0]      adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 12'h000;
        sel_o = 4'hF;
        dat_o = 32'h00000000;
    end

    // One request, held until ack is sampled; then at least one idle cycle
    task automatic access(input logic wr, input logic [9:0] idx, input logic [7:0] wdat,
                          output logic [31:0] rdat);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= wr;
        adr_o <= {idx, 2'b00};
        dat_o <= {24'h000000, wdat};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        rdat = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // Released lines do not keep the last value
        adr_o <= ~adr_o;
        dat_o <= ~dat_o;
    endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
/*
 * Self-checking bench of the register map decoder: init gate, both port
 * windows, mirrored registers, interrupt flags and line status.
 * Assumes the host model drives the Wishbone side; events are driven here.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s expected %h seen %h", nm, e, g); end end
module testbench;
    localparam logic [7:0] REV = 8'h3C;  // Arbitrary value
    localparam logic [16:0] RST_TAB [6] = '{{drm_pkg::IX_REVISION, REV},
        {drm_pkg::IX_CHIP_RST, drm_pkg::RST_CHIP_RST}, {drm_pkg::IX_XCVR_CTL, drm_pkg::RST_XCVR_CTL},
        {drm_pkg::IX_PM_CTL, drm_pkg::RST_ZERO}, {drm_pkg::IX_TOP_EN, drm_pkg::RST_ZERO},
        {drm_pkg::IX_ROLE, drm_pkg::RST_ZERO}};
    localparam logic [8:0] RW_IX [5] = '{drm_pkg::IX_PM_CTL, drm_pkg::IX_VBUS_CTL,
        drm_pkg::IX_XCVR_CTL, drm_pkg::IX_TUNING, drm_pkg::IX_ROLE};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc, wb_stb, wb_we, wb_ack, irq, init_done, endian, width;
    logic [11:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_wdat, wb_rdat;
    logic [15:0] dev_ev = 16'h0000, host_ev = 16'h0000, cpu_ev = 16'h0000, fifo_ev = 16'h0000;
    logic [1:0] pm_done = 2'b00;
    logic [7:0] dev_line = 8'hC3;
    logic [15:0] host_line = 16'h5A81;
    logic [15:0] chip_rst, pm_ctl, vbus_ctl, xcvr_ctl, tuning, role, wake;
    logic [7:0] clk_sel, cpu_cfg;
    int mismatches = 0;
    int samples_checked = 0;

    always #5 clk_i = ~clk_i;

    drm_host_model u_drm_host_model (.clk_i(clk_i), .ack_i(wb_ack), .dat_i(wb_rdat), .cyc_o(wb_cyc),
        .stb_o(wb_stb), .we_o(wb_we), .adr_o(wb_adr), .sel_o(wb_sel), .dat_o(wb_wdat));

    drm_decoder #(.REVISION(REV)) u_drm_decoder (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .dev_event_i(dev_ev), .host_event_i(host_ev),
        .cpu_event_i(cpu_ev), .fifo_event_i(fifo_ev), .pm_done_i(pm_done), .dev_line_i(dev_line),
        .host_line_i(host_line), .irq_o(irq), .init_done_o(init_done), .endian_o(endian),
        .bus_width_select_o(width), .chip_reset_o(chip_rst), .pm_ctl_o(pm_ctl), .vbus_ctl_o(vbus_ctl),
        .xcvr_ctl_o(xcvr_ctl), .tuning_o(tuning), .role_o(role), .wake_timer_o(wake),
        .clock_source_choice_o(clk_sel), .cpu_config_o(cpu_cfg));

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] unused;
        u_drm_host_model.access(1'b1, idx, d, unused);
    endtask

    task automatic chk_rd(input logic [9:0] idx, input logic [7:0] e);
        logic [31:0] got;
        u_drm_host_model.access(1'b0, idx, 8'h00, got);
        `CHK($sformatf("register %h", idx), {24'h000000, e}, got)
    endtask

    task automatic pulse(input logic [15:0] d, input logic [15:0] h, input logic [15:0] c,
                         input logic [15:0] f, input logic [1:0] pm);
        @(posedge clk_i);
        dev_ev <= d;
        host_ev <= h;
        cpu_ev <= c;
        fifo_ev <= f;
        pm_done <= pm;
        @(posedge clk_i);
        {dev_ev, host_ev, cpu_ev, fifo_ev, pm_done} <= '0;
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        give_verdict();
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        `CHK("chip reset out", 16'h8080, chip_rst)
        `CHK("xcvr out", 16'h9191, xcvr_ctl)
        chk_rd(10'h011, 8'h00);
        // Software configures the bus with its first write, after one read
        wr(10'h012, 8'h06);
        `CHK("init done", 1'b1, init_done)
        `CHK("endian", 1'b1, endian)
        `CHK("width", 1'b1, width)
        chk_rd(10'h012, 8'h00);
        wr(10'h27E, 8'h00);
        `CHK("endian kept", 1'b1, endian)
        `CHK("width kept", 1'b1, width)
        chk_rd(10'h07E, 8'h00);
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 6; k++) begin
                chk_rd({p[0], RST_TAB[k][16:8]}, RST_TAB[k][7:0]);
            end
        end
        for (int k = 0; k < 5; k++) begin
            wr({1'b0, RW_IX[k]}, {4'h3, 4'(k)});
            wr({1'b1, RW_IX[k]}, {4'hC, 4'(k)});
        end
        for (int k = 0; k < 5; k++) begin
            chk_rd({1'b0, RW_IX[k]}, {4'h3, 4'(k)});
            chk_rd({1'b1, RW_IX[k]}, {4'hC, 4'(k)});
        end
        `CHK("pm out", 16'hC030, pm_ctl)
        `CHK("vbus out", 16'hC131, vbus_ctl)
        `CHK("xcvr out", 16'hC232, xcvr_ctl)
        `CHK("tuning out", 16'hC333, tuning)
        `CHK("role out", 16'hC434, role)
        wr(10'h214, 8'hAB);
        wr(10'h015, 8'hCD);
        wr(10'h273, 8'h5C);
        wr(10'h075, 8'h07);
        chk_rd(10'h014, 8'hAB);
        chk_rd(10'h215, 8'hCD);
        chk_rd(10'h073, 8'h5C);
        chk_rd(10'h275, 8'h07);
        `CHK("wake timer", 16'hABCD, wake)
        `CHK("clock choice", 8'h5C, clk_sel)
        `CHK("cpu config", 8'h07, cpu_cfg)
        chk_rd(10'h018, 8'hC3);
        chk_rd(10'h019, 8'h81);
        chk_rd(10'h219, 8'h5A);
        chk_rd(10'h218, 8'h00);
        wr(10'h209, 8'hFF);
        chk_rd(10'h209, 8'h00);
        wr(10'h005, 8'hFF);
        chk_rd(10'h005, 8'h00);
        chk_rd(10'h3FF, 8'h00);
        wr(10'h009, 8'h81);
        wr(10'h008, 8'h81);
        pulse(16'hFF81, 16'h4000, 16'h0203, 16'h0004, 2'b01);
        chk_rd(10'h001, 8'h81);
        chk_rd(10'h201, 8'h00);
        chk_rd(10'h202, 8'h40);
        chk_rd(10'h003, 8'h03);
        chk_rd(10'h203, 8'h02);
        chk_rd(10'h004, 8'h04);
        chk_rd(10'h000, 8'h81);
        chk_rd(10'h200, 8'h00);
        chk_rd(10'h206, 8'h01);
        `CHK("irq raised", 1'b1, irq)
        wr(10'h008, 8'h00);
        chk_rd(10'h006, 8'h00);
        `CHK("irq masked", 1'b0, irq)
        wr(10'h0E1, 8'hFF);
        wr(10'h0E0, 8'h01);
        wr(10'h001, 8'hFF);
        wr(10'h008, 8'h81);
        chk_rd(10'h001, 8'h00);
        chk_rd(10'h000, 8'h00);
        `CHK("irq cleared", 1'b0, irq)
        give_verdict();
    end
endmodule
`default_nettype wire
